// file: logic/nested_irq_defines.svh
/*
  Offsets, field positions and reset values of the nested interrupt
  priority block. Assumes byte address = 4 x register index.
*/
`ifndef NESTED_IRQ_DEFINES_SVH
`define NESTED_IRQ_DEFINES_SVH

// Register indices, byte address is the index times four
`define IDX_PIN_EN_LOW 6'h08
`define IDX_ISP0 6'h32
`define IDX_ISP1 6'h33
`define IDX_ISP2 6'h34
`define IDX_ISP3 6'h35
`define IDX_PIN_EN_SENSE 6'h39
`define IDX_CC 6'h3a

// Reset values
`define RST_PIN_EN 8'h00
`define RST_ISP 8'hff
`define RST_CC 8'hfa

// Fields
`define CC_LVL_HI 5
`define CC_LVL_LO 3
`define CC_TOP_ONES 2'b11
`define SENSE_11_12 7:6
`define SENSE_9_10 5:4
`define EN_9_12 3:0
`define ISP3_RO 4'hf
`define LVL0_CODE 2'b10
`define LVL3_CODE 2'b11
`define LVL3_RANK 2'd3

// Sensitivity codes for pins 9 to 12
`define SENSE_LOW 2'b00
`define SENSE_RISE 2'b01
`define SENSE_FALL 2'b10
`define SENSE_BOTH 2'b11

// Vector codes and fixed maps
`define VEC_PORTA 4'h2
`define VEC_PORTB 4'h3
`define VEC_PORTC 4'h4
`define VEC_LAST 4'ha
`define VEC_TLI 4'he
`define VEC_TRAP 4'hf
`define WAKE_MASK 11'h0df
`define PIN_RISE_MASK 8'h30

`endif

// file: logic/nested_irq_pkg.sv
/*
  Types shared by the nested interrupt priority block.
  Assumes nothing of its surroundings.
*/
`default_nettype none
package nested_irq_pkg;

  // Core side controls
  typedef struct packed {
    logic entryTake;
    logic trapReq;
    logic ccLoad;
    logic [7:0] ccData;
    logic inHalt;
  } cpuCtl_type;

  // Request shown to the core
  typedef struct packed {
    logic req;
    logic [3:0] vec;
  } irqSel_type;

endpackage : nested_irq_pkg
`default_nettype wire

// file: logic/nested_irq_priority_ctrl.sv
/*
  Nested interrupt priority controller: priority registers, condition
  code level bits, pin interrupt detection and arbitration.
  Assumes a classic Wishbone master, a core that pulses entryTake when
  it enters the vector shown, and peripheral requests held as levels.
*/
// Local design decision: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "nested_irq_defines.svh"
// Function
// - Current level sits in flag bits 5 and 3; codes 10,01,00,11.
// - Entering a maskable vector loads its stored level into the flags; vector 0 loads level 3 instead.
// - Core instructions may load the current level bits.
// - Top pin, trap and reset still taken at level 3; others blocked.
// - Flags reset to 111x1010, level 3.
// - Four priority registers, two bits per vector, vector 0 lowest.
// - Priority registers reset to all ones.
// - Upper nibble of fourth priority register read-only ones.
// - Writing level 0 code into a pair keeps its old value.
// - Reset, trap, top pin entry set both level bits.
// - Vector 0 bits readable, writable, but ignored.
// - Raised level while pending re-enters; otherwise next request.
// - Low enable register enables pins 1 to 8, resets zero.
// - Pins 5,6 rising edge; pins 1-4,7,8 falling edge.
// - High register bits 3:0 enable pins 9 to 12, resets zero.
// - Bits 7:6 select sensitivity of pins 11 and 12.
// - Bits 5:4 select sensitivity of pins 9 and 10.
// - Fixed hardware priority by vector number, lower number wins.
// - Pins 1-4 vector 2, 5-8 vector 3, 9-12 vector 4.
// - Only listed sources wake from halt.
// - Highest level first, ties by hardware priority, latched until won.
// - Maskable taken only if pending and level above current.
// - Edge requests latched, cleared on entry.
// - Enabled pins combined by a NAND per vector; vector 4 has one NAND per pin pair.
module nested_irq_priority_ctrl (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire nested_irq_pkg::cpuCtl_type cpuCtl,
  input wire logic [7:0] periphReq,
  input wire logic [11:0] pinIn,
  input wire logic tliPin,
  output nested_irq_pkg::irqSel_type irqSel,
  output logic [7:0] ccFlags,
  output logic wakeHalt
);

  ////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic [1:0] levelRank(input logic [1:0] code);
    case (code)
      2'b10: levelRank = 2'd0;
      2'b01: levelRank = 2'd1;
      2'b00: levelRank = 2'd2;
      default: levelRank = 2'd3;
    endcase
  endfunction : levelRank

  function automatic logic [7:0] keepLevel0(input logic [7:0] prev,
                                            input logic [7:0] wr);
    keepLevel0 = wr;
    for (int i = 0; i < 4; i++) begin
      if (wr[2*i +: 2] == `LVL0_CODE) begin
        keepLevel0[2*i +: 2] = prev[2*i +: 2];
      end
    end
  endfunction : keepLevel0

  function automatic logic grpNand(input logic [3:0] p,
                                   input logic [3:0] e);
    grpNand = ~&(p | ~e);
  endfunction : grpNand

  ////////////////////////////////////////////////////////////////////
  // Declarations

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] rdMux;
  logic access;
  logic [5:0] idx;
  logic wrEn;
  logic [7:0] pinEnLow_q;
  logic [7:0] pinEnSense_q;
  logic [7:0] isp_q [0:3];
  logic [7:0] cc_q;
  logic [27:0] ispAll;
  logic [11:0] pinEn;
  logic [12:0] s1_q;
  logic [12:0] s2_q;
  logic [12:0] s3_q;
  logic [12:0] lvl_q;
  logic [12:0] agree;
  logic [7:0] act;
  logic [1:0] inv9;
  logic [1:0] inv11;
  logic [3:0] g;
  logic [3:0] nand_q;
  logic [3:0] rise;
  logic [3:0] fall;
  logic [3:0] ev;
  logic levelReq;
  logic [2:0] pinLat_q;
  logic tliPrev_q;
  logic tliPend_q;
  logic trapPend_q;
  logic [10:0] pendV;
  logic take;
  logic [1:0] entryLvl;
  logic [1:0] curRank;
  logic [1:0] rCand;
  logic [1:0] bestRank;
  logic [3:0] bestVec;
  logic found;
  nested_irq_pkg::irqSel_type nextSel;
  nested_irq_pkg::irqSel_type irqSel_q;
  logic wakeHalt_q;

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irqSel = irqSel_q;
  assign ccFlags = cc_q;
  assign wakeHalt = wakeHalt_q;

  ////////////////////////////////////////////////////////////////////
  // Wishbone slave, answer one cycle after the strobe

  assign access = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[7:2];
  assign wrEn = access & ack_q & wb_we_i & wb_sel_i[0];

  always_comb begin
    case (idx)
      `IDX_PIN_EN_LOW: rdMux = pinEnLow_q;
      `IDX_ISP0: rdMux = isp_q[0];
      `IDX_ISP1: rdMux = isp_q[1];
      `IDX_ISP2: rdMux = isp_q[2];
      `IDX_ISP3: rdMux = isp_q[3];
      `IDX_PIN_EN_SENSE: rdMux = pinEnSense_q;
      `IDX_CC: rdMux = cc_q;
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= access & ~ack_q;
      if (access && !ack_q) begin
        rdat_q <= {24'h00_0000, rdMux};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin enable and sensitivity registers

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinEnLow_q <= `RST_PIN_EN;
      pinEnSense_q <= `RST_PIN_EN;
    end else if (wrEn && idx == `IDX_PIN_EN_LOW) begin
      pinEnLow_q <= wb_dat_i[7:0];
    end else if (wrEn && idx == `IDX_PIN_EN_SENSE) begin
      pinEnSense_q <= wb_dat_i[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Vector priority registers

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < 4; k++) begin
        isp_q[k] <= `RST_ISP;
      end
    end else if (wrEn) begin
      for (int k = 0; k < 3; k++) begin
        if (idx == `IDX_ISP0 + 6'(k)) begin
          isp_q[k] <= keepLevel0(isp_q[k], wb_dat_i[7:0]);
        end
      end
      if (idx == `IDX_ISP3) begin
        isp_q[3] <= keepLevel0(isp_q[3], {`ISP3_RO, wb_dat_i[3:0]});
      end
    end
  end

  assign ispAll = {isp_q[3][3:0], isp_q[2], isp_q[1], isp_q[0]};

  ////////////////////////////////////////////////////////////////////
  // Condition code flags

  assign take = cpuCtl.entryTake & irqSel_q.req;
  // Vector 0 pair is not used for arbitration or entry
  assign entryLvl = (irqSel_q.vec > `VEC_LAST || irqSel_q.vec == 4'h0) ?
                    `LVL3_CODE : ispAll[{irqSel_q.vec, 1'b0} +: 2];
  assign curRank = levelRank({cc_q[`CC_LVL_HI], cc_q[`CC_LVL_LO]});

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cc_q <= `RST_CC;
    end else if (take) begin
      cc_q[`CC_LVL_HI] <= entryLvl[1];
      cc_q[`CC_LVL_LO] <= entryLvl[0];
    end else if (cpuCtl.ccLoad) begin
      cc_q <= {`CC_TOP_ONES, cpuCtl.ccData[5:0]};
    end else if (wrEn && idx == `IDX_CC) begin
      cc_q <= {`CC_TOP_ONES, wb_dat_i[5:0]};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisers, change taken when the last two stages agree

  assign agree = ~(s2_q ^ s3_q);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_q <= '1;
      s2_q <= '1;
      s3_q <= '1;
      lvl_q <= '1;
    end else begin
      s1_q <= {tliPin, pinIn};
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= (lvl_q & ~agree) | (s2_q & agree);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Group NAND and edge detection

  assign pinEn = {pinEnSense_q[`EN_9_12], pinEnLow_q};
  assign act = lvl_q[7:0] ^ `PIN_RISE_MASK;
  assign inv9 = {2{pinEnSense_q[`SENSE_9_10] == `SENSE_RISE}};
  assign inv11 = {2{pinEnSense_q[`SENSE_11_12] == `SENSE_RISE}};
  assign g[0] = grpNand(act[3:0], pinEn[3:0]);
  assign g[1] = grpNand(act[7:4], pinEn[7:4]);
  assign g[2] = grpNand({2'b11, lvl_q[9:8] ^ inv9}, {2'b00, pinEn[9:8]});
  assign g[3] = grpNand({2'b11, lvl_q[11:10] ^ inv11}, {2'b00, pinEn[11:10]});
  assign rise = g & ~nand_q;
  assign fall = ~g & nand_q;
  assign ev[0] = rise[0];
  assign ev[1] = rise[1];
  assign ev[2] = rise[2] | (pinEnSense_q[`SENSE_9_10] == `SENSE_BOTH & fall[2]);
  assign ev[3] = rise[3] | (pinEnSense_q[`SENSE_11_12] == `SENSE_BOTH & fall[3]);
  assign levelReq = (pinEnSense_q[`SENSE_9_10] == `SENSE_LOW & g[2]) |
                    (pinEnSense_q[`SENSE_11_12] == `SENSE_LOW & g[3]);

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      nand_q <= 4'h0;
      tliPrev_q <= 1'b1;
    end else begin
      nand_q <= g;
      tliPrev_q <= lvl_q[12];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Request latches, a new event wins over the entry clear

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      pinLat_q <= 3'h0;
    end else begin
      pinLat_q[0] <= ev[0] | (pinLat_q[0] & ~(take & irqSel_q.vec == `VEC_PORTA));
      pinLat_q[1] <= ev[1] | (pinLat_q[1] & ~(take & irqSel_q.vec == `VEC_PORTB));
      pinLat_q[2] <= ev[2] | ev[3] |
                     (pinLat_q[2] & ~(take & irqSel_q.vec == `VEC_PORTC));
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tliPend_q <= 1'b0;
      trapPend_q <= 1'b0;
    end else begin
      tliPend_q <= (tliPrev_q & ~lvl_q[12]) |
                   (tliPend_q & ~(take & irqSel_q.vec == `VEC_TLI));
      trapPend_q <= cpuCtl.trapReq |
                    (trapPend_q & ~(take & irqSel_q.vec == `VEC_TRAP));
    end
  end

  assign pendV = {periphReq[7:2], pinLat_q[2] | levelReq, pinLat_q[1:0],
                  periphReq[1:0]};

  ////////////////////////////////////////////////////////////////////
  // Arbitration

  always_comb begin
    found = 1'b0;
    bestVec = 4'h0;
    bestRank = 2'd0;
    rCand = 2'd0;
    for (int v = 0; v < 11; v++) begin
      rCand = (v == 0) ? `LVL3_RANK : levelRank(ispAll[2*v +: 2]);
      // Strict compare keeps the lower vector on a tie
      if (pendV[v] && rCand > curRank &&
          (!cpuCtl.inHalt || ((`WAKE_MASK >> v) & 11'h001) != 11'h000) &&
          (!found || rCand > bestRank)) begin
        found = 1'b1;
        bestVec = 4'(v);
        bestRank = rCand;
      end
    end
    if (tliPend_q) begin
      nextSel = {1'b1, `VEC_TLI};
    end else if (trapPend_q) begin
      nextSel = {1'b1, `VEC_TRAP};
    end else begin
      nextSel = {found, bestVec};
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      irqSel_q <= '0;
    end else if (take) begin
      irqSel_q.req <= 1'b0;
    end else begin
      irqSel_q <= nextSel;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wakeHalt_q <= 1'b0;
    end else begin
      wakeHalt_q <= tliPend_q | (|(pendV & `WAKE_MASK));
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  sequence s_ispWriteL0;
    wrEn && idx == `IDX_ISP0 && wb_dat_i[1:0] == `LVL0_CODE;
  endsequence

  sequence s_takeMaskable;
    take && irqSel_q.vec inside {[4'h1:`VEC_LAST]};
  endsequence

  a_isp_keep_level0: assert property (s_ispWriteL0 |=>
    isp_q[0][1:0] == $past(isp_q[0][1:0]))
    else $error("level 0 code was stored");
  a_isp3_upper_ro: assert property (ack_q && !wb_we_i &&
    idx == `IDX_ISP3 |-> wb_dat_o[7:4] == `ISP3_RO)
    else $error("upper nibble not ones");
  a_entry_load_lvl: assert property (s_takeMaskable |=>
    {cc_q[`CC_LVL_HI], cc_q[`CC_LVL_LO]} == $past(entryLvl))
    else $error("level not loaded on entry");
  a_entry_nmi_top: assert property (take && irqSel_q.vec > `VEC_LAST |=>
    cc_q[`CC_LVL_HI] && cc_q[`CC_LVL_LO])
    else $error("level bits not set on entry");
  a_tli_at_top: assert property (tliPend_q && curRank == 2'd3 |->
    ##[0:2] irqSel_q.req && irqSel_q.vec == `VEC_TLI)
    else $error("top pin request not shown");
  a_block_at_top: assert property (irqSel_q.req && $past(curRank) == 2'd3
    |-> irqSel_q.vec > `VEC_LAST)
    else $error("maskable shown at level 3");
  a_pin_latch_clr: assert property (take && irqSel_q.vec == `VEC_PORTA
    |=> !pinLat_q[0] || $past(ev[0]))
    else $error("pin latch not cleared");
  a_halt_wake_only: assert property (irqSel_q.req &&
    irqSel_q.vec <= `VEC_LAST && $past(cpuCtl.inHalt) && !$past(take) |->
    ((`WAKE_MASK >> irqSel_q.vec) & 11'h001) != 11'h000)
    else $error("non-wake source in halt");
  a_cc_top_ones: assert property (cc_q[7:6] == `CC_TOP_ONES)
    else $error("flag bits 7:6 not ones");
  a_sync_filter: assert property ($changed(lvl_q[0]) |->
    $past(agree[0]))
    else $error("pin changed without agreement");

endmodule : nested_irq_priority_ctrl
`default_nettype wire

// file: sim/cpu_core_model.sv
/*
  Core-side partner: enters every shown request while allowed, counts
  entries, passes flag loads and traps from the bench.
  Assumes the controller's one-cycle core handshake.
*/
`timescale 1ns/10ps
`default_nettype none
module cpu_core_model (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire nested_irq_pkg::irqSel_type irqSel,
  input wire logic takeEn,
  input wire logic loadStb,
  input wire logic [7:0] loadData,
  input wire logic trapStb,
  input wire logic halt,
  output nested_irq_pkg::cpuCtl_type cpuCtl,
  output logic [7:0] takeCnt_q,
  output logic [3:0] lastVec_q
);
  logic take_q;
  ////////////////////////////////////////////////////////////////
  // One-cycle entry pulse, never back to back
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      take_q <= 1'b0;
    end else begin
      take_q <= irqSel.req && takeEn && !take_q;
    end
  end
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      takeCnt_q <= 8'h00;
      lastVec_q <= 4'h0;
    end else if (take_q && irqSel.req) begin
      takeCnt_q <= takeCnt_q + 8'h01;
      lastVec_q <= irqSel.vec;
    end
  end
  // Flag loads and trap pass straight through
  assign cpuCtl = '{entryTake: take_q, trapReq: trapStb, ccLoad: loadStb,
                    ccData: loadData, inHalt: halt};
endmodule : cpu_core_model
`default_nettype wire

// file: sim/tb_top.sv
/*
  Self-checking bench of the nested interrupt priority controller.
  Assumes cpu_core_model as the core and the bench as pins and bus.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys, nrst, cyc, stb, we, ack, takeEn, loadStb, trapStb, tliPin, halt, wakeHalt;
  logic [3:0] sel, lastVec;
  logic [7:0] adr, rd, base, loadData, periphReq, takeCnt, ccFlags;
  logic [31:0] wdat, datO;
  logic [11:0] pinIn;
  nested_irq_pkg::cpuCtl_type cpuCtl;
  nested_irq_pkg::irqSel_type irqSel;
  int n_errors, compares, cycles;
  nested_irq_priority_ctrl i_nested_irq_priority_ctrl (.clk_sys(clk_sys), .nrst(nrst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack), .cpuCtl(cpuCtl),
    .periphReq(periphReq), .pinIn(pinIn), .tliPin(tliPin), .irqSel(irqSel),
    .ccFlags(ccFlags), .wakeHalt(wakeHalt));
  cpu_core_model i_cpu_core_model (.clk_sys(clk_sys), .nrst(nrst), .irqSel(irqSel),
    .takeEn(takeEn), .loadStb(loadStb), .loadData(loadData), .trapStb(trapStb),
    .halt(halt), .cpuCtl(cpuCtl), .takeCnt_q(takeCnt), .lastVec_q(lastVec));
  ////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : summarize
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do begin
      @(posedge clk_sys);
    end while (ack !== 1'b1);
    rd = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    wb(1'b0, a, 8'h00);
    check(what, rd, exp);
  endtask : rchk
  task automatic setcc(input logic [7:0] v);
    @(posedge clk_sys);
    loadStb <= 1'b1;
    loadData <= v;
    @(posedge clk_sys);
    loadStb <= 1'b0;
  endtask : setcc
  // Drain stale requests, then note the entry count
  task automatic flush();
    setcc(8'he0);
    repeat (12) @(posedge clk_sys);
    setcc(8'he0);
    base = takeCnt;
  endtask : flush
  task automatic took(input string what, input logic exp);
    repeat (12) @(posedge clk_sys);
    check(what, {7'h00, takeCnt != base}, {7'h00, exp});
  endtask : took
  task automatic showN(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : showN
  ////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    {nrst, cyc, stb, we, takeEn, loadStb, trapStb, halt} = 8'h00;
    {adr, wdat, loadData, periphReq, base} = 64'h0;
    sel = 4'hf;
    tliPin = 1'b1;
    pinIn = 12'hfff;
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    rchk(8'h20, 8'h00, "pin enable low");
    for (int i = 0; i < 4; i++) begin
      rchk(8'hc8 + 8'(4 * i), 8'hff, "vector priority");
    end
    rchk(8'he4, 8'h00, "pin enable sense");
    rchk(8'h04, 8'h00, "unmapped");
    check("flags", ccFlags & 8'he8, 8'he8);
    wb(1'b0, 8'he8, 8'h00);
    check("flags read", rd & 8'he8, 8'he8);
    wb(1'b1, 8'hd4, 8'h00);
    rchk(8'hd4, 8'hf0, "fourth priority");
    wb(1'b1, 8'hcc, 8'hcf);
    wb(1'b1, 8'hcc, 8'h64);
    rchk(8'hcc, 8'h44, "level0 write");
    takeEn <= 1'b1;
    wb(1'b1, 8'hc8, 8'hde);
    rchk(8'hc8, 8'hdf, "level0 keep");
    wb(1'b1, 8'h20, 8'h03);
    flush();
    pinIn[0] <= 1'b0;
    took("pin1 fall", 1'b1);
    check("pin1 vector", {4'h0, lastVec}, 8'h02);
    check("entry level", ccFlags & 8'h28, 8'h08);
    setcc(8'he0);
    base = takeCnt;
    pinIn[1] <= 1'b0;
    took("pin2 masked", 1'b0);
    pinIn[1:0] <= 2'b11;
    took("pin rise", 1'b0);
    wb(1'b1, 8'h20, 8'h10);
    flush();
    pinIn[4] <= 1'b0;
    took("pin5 fall", 1'b0);
    pinIn[4] <= 1'b1;
    took("pin5 rise", 1'b1);
    check("pin5 vector", {4'h0, lastVec}, 8'h03);
    wb(1'b1, 8'h20, 8'h00);
    for (int p = 0; p < 2; p++) begin
      for (int m = 0; m < 4; m++) begin
        wb(1'b1, 8'he4, p ? {2'(m), 6'h04} : {2'b00, 2'(m), 4'h1});
        flush();
        pinIn[8 + 2 * p] <= 1'b0;
        took("sense fall", m != 1);
        base = takeCnt;
        pinIn[8 + 2 * p] <= 1'b1;
        showN(12);
        setcc(8'he0);
        took("sense rise", m[0]);
      end
    end
    wb(1'b1, 8'he4, 8'h00);
    takeEn <= 1'b0;
    periphReq <= 8'h0c;
    setcc(8'he0);
    showN(4);
    check("level wins", {4'h0, irqSel.vec}, 8'h06);
    wb(1'b1, 8'hcc, 8'h00);
    showN(4);
    check("tie order", {4'h0, irqSel.vec}, 8'h05);
    setcc(8'hc0);
    showN(4);
    check("not above", {7'h00, irqSel.req}, 8'h00);
    setcc(8'hc8);
    showN(4);
    check("above", {7'h00, irqSel.req}, 8'h01);
    periphReq <= 8'h04;
    showN(4);
    check("no wake", {7'h00, wakeHalt}, 8'h00);
    periphReq <= 8'h08;
    showN(4);
    check("wake", {7'h00, wakeHalt}, 8'h01);
    halt <= 1'b1;
    periphReq <= 8'h0c;
    showN(4);
    check("halt pick", {3'h0, irqSel}, 8'h16);
    halt <= 1'b0;
    periphReq <= 8'h00;
    setcc(8'he8);
    trapStb <= 1'b1;
    @(posedge clk_sys);
    trapStb <= 1'b0;
    showN(4);
    check("trap at 3", {3'h0, irqSel}, 8'h1f);
    setcc(8'he0);
    takeEn <= 1'b1;
    showN(6);
    check("trap level", ccFlags & 8'h28, 8'h28);
    takeEn <= 1'b0;
    setcc(8'he8);
    tliPin <= 1'b0;
    showN(8);
    check("top pin at 3", {3'h0, irqSel}, 8'h1e);
    setcc(8'he0);
    takeEn <= 1'b1;
    showN(6);
    check("top pin level", ccFlags & 8'h28, 8'h28);
    check("top pin vector", {4'h0, lastVec}, 8'h0e);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
